/* File: rtl/upt_bank.sv */
// Uptime counter and program mapping selection tables
//
// Contract
// - Count elapsed operating time in whole seconds since controller start.
// - Counter is not retained; restarts from zero at every power-on.
// - Counter is 32-bit unsigned, read only, PDO mappable, preset zero.
// - Input table lists objects copied into program input before execution.
// - Output table lists objects copied from program output after execution.
// - In/out table objects are copied in first, then copied back out.
// - Each table holds sixteen entries, each a different mapped object.
// - Descriptor: bits 31-16 index, 15-8 subindex, 7-0 length.
// - Descriptor length counts bits, not bytes.
// - Subindex zero reads sixteen as highest supported entry, read only.
// - Descriptor entries are read only from the fieldbus, preset zero.
`timescale 1ns/10ps
`default_nettype none
module upt_bank #(
  parameter int TICK_CYCLES = upt_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire upt_pkg::upt_req_s host_req,
  output upt_pkg::upt_rsp_s host_rsp,
  input wire upt_pkg::upt_load_s load,
  input wire logic copy_in_start,
  input wire logic copy_out_start,
  output upt_pkg::upt_desc_s desc_out,
  output logic copy_done,
  output logic [31:0] uptime
);
  import upt_pkg::*;

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [31:0] up;
    logic [31:0] tick;
    upt_st_e st;
    logic [4:0] pos;
    logic [NUM_TABLES-1:0][NUM_ENTRIES-1:0][31:0] tbl;
    upt_rsp_s rsp;
    upt_desc_s desc;
    logic done;
  } upt_state_s;

  upt_state_s q;
  upt_state_s d;

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    logic [7:0] sub_m1;
    logic [31:0] word;
    upt_tbl_e wt;
    sub_m1 = host_req.sub - 8'h01;
    word = DESC_RESET;
    wt = TBL_IN;
    d = q;
    d.rsp.ack = 1'b0;
    d.rsp.err = 1'b0;
    d.desc.valid = 1'b0;
    d.done = 1'b0;

    // One-second tick and uptime
    if (q.tick >= TICK_LAST) begin
      d.tick = 32'h0000_0000;
      d.up = q.up + 32'h0000_0001;
    end else begin
      d.tick = q.tick + 32'h0000_0001;
    end

    // Dictionary access
    if (host_req.rd || host_req.wr) begin
      d.rsp.ack = 1'b1;
      d.rsp.data = 32'h0000_0000;
      if (host_req.wr) begin
        d.rsp.err = 1'b1;
        d.rsp.data = ERR_READ_ONLY;
      end else begin
        unique case (host_req.index)
          IDX_UPTIME: begin
            if (host_req.sub == 8'h00) begin
              d.rsp.data = q.up;
            end else begin
              d.rsp.err = 1'b1;
              d.rsp.data = ERR_NO_OBJECT;
            end
          end
          IDX_IN_SEL, IDX_OUT_SEL, IDX_IO_SEL: begin
            if (host_req.sub == 8'h00) begin
              d.rsp.data = {24'h00_0000, HIGHEST_SUB};
            end else if (host_req.sub <= HIGHEST_SUB) begin
              d.rsp.data = q.tbl[host_req.index[5:4] - 2'h1][sub_m1[3:0]];
            end else begin
              d.rsp.err = 1'b1;
              d.rsp.data = ERR_NO_OBJECT;
            end
          end
          default: begin
            d.rsp.err = 1'b1;
            d.rsp.data = ERR_NO_OBJECT;
          end
        endcase
      end
    end

    // Program loader fills tables only while no copy walk runs
    if (load.we && q.st == ST_IDLE) begin
      d.tbl[load.tsel][load.entry] = load.desc;
    end

    // Copy walks: own table first, then the in/out table
    unique case (q.st)
      ST_IDLE: begin
        d.pos = 5'h00;
        if (copy_in_start) begin
          d.st = ST_COPY_IN;
        end else if (copy_out_start) begin
          d.st = ST_COPY_OUT;
        end
      end
      ST_COPY_IN, ST_COPY_OUT: begin
        if (q.pos[4]) begin
          wt = TBL_IO;
        end else if (q.st == ST_COPY_IN) begin
          wt = TBL_IN;
        end else begin
          wt = TBL_OUT;
        end
        word = q.tbl[wt][q.pos[3:0]];
        d.desc.valid = (word != DESC_RESET);
        d.desc.dir = (q.st == ST_COPY_OUT);
        d.desc.tsel = wt;
        d.desc.idx = word[DESC_IDX_LSB +: 16];
        d.desc.sub = word[DESC_SUB_LSB +: 8];
        d.desc.len = word[DESC_LEN_LSB +: 8];
        d.pos = q.pos + 5'h01;
        if (q.pos == WALK_LAST) begin
          d.st = ST_IDLE;
          d.done = 1'b1;
        end
      end
    endcase
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.up <= UPTIME_RESET;
      q.st <= ST_IDLE;
      for (int t = 0; t < NUM_TABLES; t++) begin
        for (int e = 0; e < NUM_ENTRIES; e++) begin
          q.tbl[t][e] <= DESC_RESET;
        end
      end
    end else begin
      q <= d;
    end
  end

  assign host_rsp = q.rsp;
  assign desc_out = q.desc;
  assign copy_done = q.done;
  assign uptime = q.up;

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence walk_start_s;
    q.st == ST_IDLE && copy_in_start;
  endsequence

  sequence in_phase_s;
    q.st == ST_COPY_IN && q.pos[4];
  endsequence

  sequence walk_out_s;
    q.st == ST_IDLE && !copy_in_start && copy_out_start;
  endsequence

  uptime_step_a: assert property (rst_n && q.tick >= TICK_LAST
      |=> uptime == $past(uptime) + 32'h1)
    else $error("uptime did not advance on tick");
  uptime_hold_a: assert property (rst_n && q.tick < TICK_LAST |=> $stable(uptime))
    else $error("uptime moved without tick");
  uptime_clear_a: assert property (disable iff (1'b0) !rst_n
      |=> uptime == 32'h0 && !host_rsp.ack && !desc_out.valid && !copy_done)
    else $error("outputs not cleared by reset");
  uptime_restart_a: assert property ($rose(rst_n) |-> uptime == 32'h0 && q.tick == 32'h0)
    else $error("uptime not zero after reset");
  uptime_read_a: assert property (host_req.rd && host_req.index == IDX_UPTIME
      && host_req.sub == 8'h00 |=> host_rsp.ack && !host_rsp.err
      && host_rsp.data == $past(uptime))
    else $error("uptime read mismatch");
  highest_sub_a: assert property (host_req.rd && !host_req.wr && host_req.index == IDX_OUT_SEL
      && host_req.sub == 8'h00 |=> host_rsp.data == 32'h10)
    else $error("highest subindex not sixteen");
  write_refused_a: assert property (host_req.wr |=> host_rsp.ack && host_rsp.err
      && host_rsp.data == ERR_READ_ONLY)
    else $error("fieldbus write not refused");
  entry_range_a: assert property (host_req.rd && !host_req.wr && host_req.index == IDX_IN_SEL
      && host_req.sub == 8'h11 |=> host_rsp.err)
    else $error("entry seventeen accepted");
  walk_length_a: assert property (walk_start_s |-> ##33 copy_done)
    else $error("copy walk length wrong");
  walk_out_len_a: assert property (walk_out_s |-> ##33 copy_done)
    else $error("output walk length wrong");
  inout_second_a: assert property (in_phase_s |=> desc_out.tsel == TBL_IO && !desc_out.dir)
    else $error("in/out table not walked second");
  out_dir_a: assert property (q.st == ST_COPY_OUT && !q.pos[4]
      |=> desc_out.tsel == TBL_OUT && desc_out.dir)
    else $error("output walk used wrong table");
  desc_field_a: assert property (desc_out.valid |-> {desc_out.idx, desc_out.sub,
      desc_out.len} != 32'h0)
    else $error("empty descriptor emitted");
endmodule
`default_nettype wire

/* File: rtl/upt_pkg.sv */
// Constants and carrier types for the uptime and mapping table bank
package upt_pkg;
  // ---------------------------------------------------------------
  // Dictionary indices
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_UPTIME = 16'h230F;
  localparam logic [15:0] IDX_IN_SEL = 16'h2310;
  localparam logic [15:0] IDX_OUT_SEL = 16'h2320;
  localparam logic [15:0] IDX_IO_SEL = 16'h2330;
  // ---------------------------------------------------------------
  // Table layout and reset values
  // ---------------------------------------------------------------
  localparam int NUM_ENTRIES = 16;
  localparam int NUM_TABLES = 3;
  localparam logic [7:0] HIGHEST_SUB = 8'h10;
  localparam logic [31:0] UPTIME_RESET = 32'h0000_0000;
  localparam logic [31:0] DESC_RESET = 32'h0000_0000;
  localparam int DESC_IDX_LSB = 16;
  localparam int DESC_SUB_LSB = 8;
  localparam int DESC_LEN_LSB = 0;
  // ---------------------------------------------------------------
  // Access abort codes
  // ---------------------------------------------------------------
  localparam logic [31:0] ERR_NO_OBJECT = 32'h0000_1000;
  localparam logic [31:0] ERR_READ_ONLY = 32'h0000_1001;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ = 25000000;
  localparam longint TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = int'(CLK_HZ * TICK_PERIOD_S);
  localparam logic [4:0] WALK_LAST = 5'h1F;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TBL_IN = 2'h0,
    TBL_OUT = 2'h1,
    TBL_IO = 2'h2
  } upt_tbl_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_COPY_IN = 3'h2,
    ST_COPY_OUT = 3'h4
  } upt_st_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] index;
    logic [7:0] sub;
  } upt_req_s;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] data;
  } upt_rsp_s;

  typedef struct packed {
    logic we;
    upt_tbl_e tsel;
    logic [3:0] entry;
    logic [31:0] desc;
  } upt_load_s;

  typedef struct packed {
    logic valid;
    logic dir;
    upt_tbl_e tsel;
    logic [15:0] idx;
    logic [7:0] sub;
    logic [7:0] len;
  } upt_desc_s;
endpackage

/* File: verif/upt_bank_tb.sv */
// Self-checking bench for the uptime and mapping table bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, s); end end
module upt_bank_tb;
  import upt_pkg::*;
  localparam int TK = 10;
  logic clk = 0;
  logic rst_n = 0;
  logic cin = 0;
  logic cout = 0;
  upt_req_s req;
  upt_rsp_s rsp;
  upt_load_s ld = '0;
  upt_desc_s d;
  logic done;
  logic [31:0] up;
  logic [31:0] u0;
  logic [31:0] tbl [3][16];
  int n_errors = 0;
  int samples_checked = 0;
  upt_bank #(.TICK_CYCLES(TK)) u_upt_bank (.clk(clk), .rst_n(rst_n), .host_req(req),
    .host_rsp(rsp), .load(ld), .copy_in_start(cin), .copy_out_start(cout),
    .desc_out(d), .copy_done(done), .uptime(up));
  upt_host u_upt_host (.clk(clk), .req(req), .rsp(rsp));
  initial forever #20 clk = ~clk;
  function automatic logic [15:0] ix(int t);
    return t == 0 ? IDX_IN_SEL : (t == 1 ? IDX_OUT_SEL : IDX_IO_SEL);
  endfunction
  task automatic ck(logic wr, logic [15:0] i, logic [7:0] s, logic e, logic [31:0] v);
    logic er;
    logic [31:0] dt;
    u_upt_host.access(wr, i, s, er, dt);
    `CHK("access", {e, v}, {er, dt})
  endtask
  task automatic walk(logic dir);
    upt_desc_s q[$];
    upt_desc_s x;
    logic [31:0] v;
    int tt;
    bit fin;
    fin = 0;
    for (int k = 0; k < 32; k++) begin
      tt = k < 16 ? int'(dir) : 2;
      v = tbl[tt][k % 16];
      if (v != 0) q.push_back('{1'b1, dir, upt_tbl_e'(tt), v[31:16], v[15:8], v[7:0]});
    end
    @(posedge clk);
    cin <= !dir;
    cout <= dir;
    @(posedge clk);
    cin <= 1'b0;
    cout <= 1'b0;
    for (int i = 0; i < 40 && !fin; i++) begin
      @(negedge clk);
      if (d.valid === 1'b1) begin
        x = q.pop_front();
        `CHK("desc", x, d)
      end
      if (done === 1'b1) fin = 1;
    end
    `CHK("left", 0, q.size())
    `CHK("done", 1, fin)
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop;
  end
  initial begin
    void'($urandom(68812));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    ck(0, IDX_UPTIME, 8'h00, 0, 32'h0000_0000);
    ck(1, IDX_UPTIME, 8'h00, 1, ERR_READ_ONLY);
    ck(0, IDX_UPTIME, 8'h01, 1, ERR_NO_OBJECT);
    ck(0, 16'h2311, 8'h00, 1, ERR_NO_OBJECT);
    for (int t = 0; t < 3; t++) begin
      ck(0, ix(t), 8'h00, 0, 32'h0000_0010);
      ck(1, ix(t), 8'h00, 1, ERR_READ_ONLY);
      ck(0, ix(t), 8'h11, 1, ERR_NO_OBJECT);
      ck(1, ix(t), 8'h01, 1, ERR_READ_ONLY);
      ck(0, ix(t), 8'h10, 0, DESC_RESET);
      for (int e = 0; e < 16; e++) begin
        tbl[t][e] = ($urandom % 4 == 0) ? 32'h0 : $urandom;
        @(posedge clk);
        ld <= '{1'b1, upt_tbl_e'(t), 4'(e), tbl[t][e]};
        @(posedge clk);
        ld <= '0;
      end
    end
    for (int t = 0; t < 3; t++) begin
      for (int e = 0; e < 16; e++) ck(0, ix(t), 8'(e + 1), 0, tbl[t][e]);
    end
    walk(0);
    walk(1);
    u0 = up;
    repeat (5 * TK) @(posedge clk);
    @(negedge clk);
    `CHK("uptime", u0 + 32'h5, up)
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    ck(0, IDX_UPTIME, 8'h00, 0, 32'h0000_0000);
    ck(0, IDX_IO_SEL, 8'h01, 0, DESC_RESET);
    report_and_stop;
  end
endmodule
`default_nettype wire

/* File: verif/upt_host.sv */
// Fieldbus host model issuing dictionary accesses
`timescale 1ns/10ps
`default_nettype none
module upt_host (
  input wire logic clk,
  output upt_pkg::upt_req_s req,
  input wire upt_pkg::upt_rsp_s rsp
);
  import upt_pkg::*;
  initial req = '0;
  // One access, answer sampled on the falling edge half a cycle after the taking edge
  task automatic access(input logic wr, input logic [15:0] i, input logic [7:0] s,
    output logic er, output logic [31:0] dt);
    @(posedge clk);
    req <= '{rd: !wr, wr: wr, index: i, sub: s};
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b0, index: ~i, sub: ~s};
    @(negedge clk);
    er = rsp.ack ? rsp.err : 1'bx;
    dt = rsp.ack ? rsp.data : 'x;
  endtask
endmodule
`default_nettype wire
